//--- design/gp_pkg.sv
/*
  Package for the general-purpose I/O port slice: register offsets,
  field codes, reset values per port flavour and the register selector.
  Assumes a 32-bit APB register bus with word-aligned byte addresses.
*/
package gp_pkg;

  localparam int unsigned GP_PINS = 16;
  localparam int unsigned GP_AW   = 12;

  // Byte offsets of the registers inside one port.
  localparam logic [11:0] GP_OFF_PIN_MODE  = 12'h000;
  localparam logic [11:0] GP_OFF_DRIVE     = 12'h004;
  localparam logic [11:0] GP_OFF_SLEW      = 12'h008;
  localparam logic [11:0] GP_OFF_PULL      = 12'h00C;
  localparam logic [11:0] GP_OFF_PIN_IN    = 12'h010;
  localparam logic [11:0] GP_OFF_LATCH     = 12'h014;
  localparam logic [11:0] GP_OFF_BIT_CLEAR = 12'h028;

  // Two-bit pin mode codes.
  localparam logic [1:0] GP_MODE_INPUT  = 2'h0;
  localparam logic [1:0] GP_MODE_OUTPUT = 2'h1;
  localparam logic [1:0] GP_MODE_ALT    = 2'h2;
  localparam logic [1:0] GP_MODE_ANALOG = 2'h3;

  // Two-bit pull codes.
  localparam logic [1:0] GP_PULL_UP   = 2'h1;
  localparam logic [1:0] GP_PULL_DOWN = 2'h2;

  // Reset values that differ between port flavours, plus the zero values shared by all.
  localparam logic [31:0] GP_RST_MODE_A  = 32'hA800_0000;
  localparam logic [31:0] GP_RST_PULL_A  = 32'h6400_0000;
  localparam logic [31:0] GP_RST_MODE_B  = 32'h0000_0280;
  localparam logic [31:0] GP_RST_SLEW_B  = 32'h0000_00C0;
  localparam logic [31:0] GP_RST_PULL_B  = 32'h0000_0100;
  localparam logic [31:0] GP_RST_ZERO    = 32'h0000_0000;
  localparam logic [15:0] GP_RST_HALF    = 16'h0000;

  typedef enum logic [1:0] {
    GP_PORT_A,
    GP_PORT_B,
    GP_PORT_OTHER
  } gp_port_t;

  typedef enum logic [2:0] {
    GP_REG_PIN_MODE,
    GP_REG_DRIVE,
    GP_REG_SLEW,
    GP_REG_PULL,
    GP_REG_PIN_IN,
    GP_REG_LATCH,
    GP_REG_BIT_CLEAR,
    GP_REG_NONE
  } gp_reg_t;

endpackage

//--- design/gp_apb_decode.sv
/*
  APB address decoder for the I/O port: classifies the current address
  into a register selector and flags the setup and write-access phases.
  Assumes APB signalling from a single master on the port clock.
*/
`timescale 1ns/1ps
module gp_apb_decode
#(
  parameter bit HAS_BIT_CLEAR = 1'b1
)
(
  // Bus request
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [gp_pkg::GP_AW-1:0] paddr_i,
  // Decoded strobes
  output gp_pkg::gp_reg_t         reg_sel_o,
  output logic                    setup_o,
  output logic                    write_o
);
  import gp_pkg::*;

  assign setup_o = psel_i & ~penable_i;
  assign write_o = psel_i & penable_i & pwrite_i;

  always_comb
  begin
    unique case (paddr_i)
      GP_OFF_PIN_MODE:  reg_sel_o = GP_REG_PIN_MODE;
      GP_OFF_DRIVE:     reg_sel_o = GP_REG_DRIVE;
      GP_OFF_SLEW:      reg_sel_o = GP_REG_SLEW;
      GP_OFF_PULL:      reg_sel_o = GP_REG_PULL;
      GP_OFF_PIN_IN:    reg_sel_o = GP_REG_PIN_IN;
      GP_OFF_LATCH:     reg_sel_o = GP_REG_LATCH;
      // Without the option the clear offset is an ordinary hole.
      GP_OFF_BIT_CLEAR: reg_sel_o = HAS_BIT_CLEAR ? GP_REG_BIT_CLEAR : GP_REG_NONE;
      default:          reg_sel_o = GP_REG_NONE;
    endcase
  end

endmodule // gp_apb_decode

//--- design/gp_pin_drive.sv
/*
  Per-pin output driver: turns mode, drive type, latch and pull fields
  into active-low output enable and pull requests for the pad.
  Assumes the pad cell resolves the wire and applies the pull resistors.
*/
`timescale 1ns/1ps
module gp_pin_drive
(
  // Configuration
  input  wire logic [31:0]          mode_i,
  input  wire logic [15:0]          drive_i,
  input  wire logic [31:0]          pull_i,
  input  wire logic [15:0]          latch_i,
  // Pad side
  output logic      [15:0]          pin_oe_n_o,
  output logic      [15:0]          pull_up_o,
  output logic      [15:0]          pull_down_o
);
  import gp_pkg::*;

  for (genvar y = 0; y < GP_PINS; y++)
  begin : g_pin
    logic out_mode;
    assign out_mode = (mode_i[2*y+:2] == GP_MODE_OUTPUT);
    // Open-drain pins only drive the low level and float otherwise.
    assign pin_oe_n_o[y] = ~(out_mode & (~drive_i[y] | ~latch_i[y]));
    // Analog pins never get a pull, whatever the field holds.
    assign pull_up_o[y]   = (mode_i[2*y+:2] != GP_MODE_ANALOG) &
                            (pull_i[2*y+:2] == GP_PULL_UP);
    assign pull_down_o[y] = (mode_i[2*y+:2] != GP_MODE_ANALOG) &
                            (pull_i[2*y+:2] == GP_PULL_DOWN);
  end

endmodule // gp_pin_drive

//--- design/gp_port.sv
/*
  Sixteen-pin general-purpose I/O port with APB register access:
  pin mode, drive type, slew, pull, input sampling, output latch and
  the optional write-only bit-clear register.
  Assumes pins are synchronous to clk_i and an external pad resolves
  output, active-low enable and pull requests.
*/
// The APB register port was decided locally.
`timescale 1ns/1ps
module gp_port
#(
  parameter gp_pkg::gp_port_t PORT          = gp_pkg::GP_PORT_OTHER,
  parameter bit               HAS_BIT_CLEAR = 1'b1
)
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [gp_pkg::GP_AW-1:0] paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Pins
  input  wire logic [15:0]          pin_in_i,
  output logic      [15:0]          pin_out_o,
  output logic      [15:0]          pin_oe_n_o,
  // Pad configuration
  output logic      [15:0]          pull_up_o,
  output logic      [15:0]          pull_down_o,
  output logic      [31:0]          slew_speed_o,
  output logic      [31:0]          pin_mode_o
);
  import gp_pkg::*;

  typedef struct packed {
    logic [31:0] pin_mode;
    logic [15:0] drive;
    logic [31:0] slew;
    logic [31:0] pull;
    logic [15:0] latch;
    logic [15:0] pin_in;
    logic [31:0] rdata;
    logic        err;
  } gp_state_t;

  // The reset image is a constant chosen by the port flavour, so the
  // asynchronous reset branch loads nothing but a fixed value.
  localparam logic [31:0] RST_MODE = (PORT == GP_PORT_A) ? GP_RST_MODE_A :
                                     (PORT == GP_PORT_B) ? GP_RST_MODE_B : GP_RST_ZERO;
  localparam logic [31:0] RST_SLEW = (PORT == GP_PORT_B) ? GP_RST_SLEW_B : GP_RST_ZERO;
  localparam logic [31:0] RST_PULL = (PORT == GP_PORT_A) ? GP_RST_PULL_A :
                                     (PORT == GP_PORT_B) ? GP_RST_PULL_B : GP_RST_ZERO;
  localparam gp_state_t   STATE_RST = '{RST_MODE, GP_RST_HALF, RST_SLEW, RST_PULL,
                                        GP_RST_HALF, GP_RST_HALF, GP_RST_ZERO, 1'b0};

  gp_state_t state_q;
  gp_state_t state_d;

  gp_reg_t   reg_sel;
  logic      setup;
  logic      write;
  logic [15:0] clear_mask;

  gp_apb_decode #(
    .HAS_BIT_CLEAR (HAS_BIT_CLEAR)
  ) u_decode (
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .reg_sel_o (reg_sel),
    .setup_o   (setup),
    .write_o   (write)
  );

  // The clear register holds no state; a write acts on the latch at once.
  assign clear_mask = (write && reg_sel == GP_REG_BIT_CLEAR) ? pwdata_i[15:0] : GP_RST_HALF;

  always_comb
  begin
    state_d        = state_q;
    // Input pins are registered every cycle so reads show a stable value.
    state_d.pin_in = pin_in_i;

    // Read data and error are captured in the setup phase so that the
    // access phase can answer with zero wait states from flip-flops.
    if (setup)
    begin
      state_d.err   = (reg_sel == GP_REG_NONE);
      state_d.rdata = GP_RST_ZERO;
      unique case (reg_sel)
        GP_REG_PIN_MODE:  state_d.rdata = state_q.pin_mode;
        GP_REG_DRIVE:     state_d.rdata = {16'h0000, state_q.drive};
        GP_REG_SLEW:      state_d.rdata = state_q.slew;
        GP_REG_PULL:      state_d.rdata = state_q.pull;
        GP_REG_PIN_IN:    state_d.rdata = {16'h0000, state_q.pin_in};
        GP_REG_LATCH:     state_d.rdata = {16'h0000, state_q.latch};
        GP_REG_BIT_CLEAR: state_d.rdata = GP_RST_ZERO;
        GP_REG_NONE:      state_d.rdata = GP_RST_ZERO;
      endcase
    end

    if (write)
    begin
      unique case (reg_sel)
        GP_REG_PIN_MODE: state_d.pin_mode = pwdata_i;
        GP_REG_DRIVE:    state_d.drive    = pwdata_i[15:0];
        GP_REG_SLEW:     state_d.slew     = pwdata_i;
        GP_REG_PULL:     state_d.pull     = pwdata_i;
        // Upper sixteen bits are reserved and simply dropped.
        GP_REG_LATCH:    state_d.latch    = pwdata_i[15:0];
        GP_REG_PIN_IN,
        GP_REG_BIT_CLEAR,
        GP_REG_NONE:     state_d.latch    = state_q.latch;
      endcase
    end

    // Only ones clear; zeros in the mask leave each latch bit as it was.
    state_d.latch = state_d.latch & ~clear_mask;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= STATE_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  gp_pin_drive u_drive (
    .mode_i      (state_q.pin_mode),
    .drive_i     (state_q.drive),
    .pull_i      (state_q.pull),
    .latch_i     (state_q.latch),
    .pin_oe_n_o  (pin_oe_n_o),
    .pull_up_o   (pull_up_o),
    .pull_down_o (pull_down_o)
  );

  assign pin_out_o    = state_q.latch;
  assign slew_speed_o = state_q.slew;
  assign pin_mode_o   = state_q.pin_mode;
  assign prdata_o     = state_q.rdata;
  assign pslverr_o    = state_q.err & psel_i & penable_i;
  // Every access completes in its first access cycle.
  assign pready_o     = 1'b1;

endmodule // gp_port

//--- testbench/gp_port_properties.sv
/* Checker for the I/O port: bit-clear, latch, map errors and pin drive.
   Assumes it is bound into every gp_port instance. */
`timescale 1ns/1ps
module gp_port_properties
  import gp_pkg::*;
#(
  parameter bit HAS_BIT_CLEAR = 1'b1
)
(
  // Clock and reset
  input wire logic             clk_i,
  input wire logic             reset_n_i,
  // APB
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [GP_AW-1:0] paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             pslverr_o,
  // Pins
  input wire logic [15:0]      pin_out_o,
  input wire logic [15:0]      pin_oe_n_o,
  input wire logic [31:0]      pin_mode_o
);
  logic rd;
  logic wr;
  assign rd = psel_i && penable_i && !pwrite_i;
  assign wr = psel_i && penable_i && pwrite_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_clear;
    wr && paddr_i == GP_OFF_BIT_CLEAR && HAS_BIT_CLEAR
      |=> pin_out_o == ($past(pin_out_o) & ~16'($past(pwdata_i)));
  endproperty
  a_clear: assert property (p_clear) else $error("bit clear wrong");
  property p_clear_read;
    rd && paddr_i == GP_OFF_BIT_CLEAR |-> prdata_o == 32'h0000_0000;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("clear read not 0");
  property p_latch_wr;
    wr && paddr_i == GP_OFF_LATCH |=> pin_out_o == 16'($past(pwdata_i));
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("latch write wrong");
  property p_latch_rd;
    rd && paddr_i == GP_OFF_LATCH |-> prdata_o == {16'h0000, pin_out_o};
  endproperty
  a_latch_rd: assert property (p_latch_rd) else $error("latch read wrong");
  property p_hold;
    !wr |=> $stable(pin_out_o);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_unmapped;
    psel_i && penable_i && (paddr_i inside {12'h018, 12'h01C, 12'h020, 12'h024}
      || (paddr_i == GP_OFF_BIT_CLEAR && !HAS_BIT_CLEAR)) |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_oe_off;
    pin_mode_o[1:0] != GP_MODE_OUTPUT |-> pin_oe_n_o[0];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_oe_on;
    pin_mode_o[1:0] == GP_MODE_OUTPUT && !pin_out_o[0] |-> !pin_oe_n_o[0];
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  c_clear: cover property (wr && paddr_i == GP_OFF_BIT_CLEAR);
  c_err: cover property (pslverr_o);
  c_drive: cover property (!pin_oe_n_o[0]);
endmodule // gp_port_properties
bind gp_port gp_port_properties #(.HAS_BIT_CLEAR(HAS_BIT_CLEAR)) i_props (.clk_i,
  .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pslverr_o, .pin_out_o, .pin_oe_n_o, .pin_mode_o);

//--- testbench/gp_port_bench.sv
/* Bench for the I/O port: three flavours (A, B, other without bit-clear)
   on one shared APB bus. Assumes the checker is bound into each. */
`timescale 1ns/1ps
module gp_port_bench;
  import gp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [GP_AW-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [15:0] pin_in_i = 16'hA5C3;
  logic [31:0] rd_w [3];
  logic [31:0] rd [3];
  logic er_w [3];
  logic er [3];
  logic rdy_w [3];
  logic [15:0] pout_w [3];
  logic [15:0] oen_w [3];
  logic [15:0] pu_w [3];
  logic [15:0] pd_w [3];
  logic [31:0] slw_w [3];
  logic [31:0] mode_w [3];
  logic [15:0] lat;
  int errors = 0;
  int checks_done = 0;
  always #25 clk_i = ~clk_i;
  for (genvar k = 0; k < 3; k++)
  begin : g_port
    gp_port #(.PORT(gp_port_t'(k)), .HAS_BIT_CLEAR(k != 2)) i_dut (.clk_i, .reset_n_i,
      .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o(rd_w[k]),
      .pready_o(rdy_w[k]), .pslverr_o(er_w[k]), .pin_in_i, .pin_out_o(pout_w[k]),
      .pin_oe_n_o(oen_w[k]), .pull_up_o(pu_w[k]), .pull_down_o(pd_w[k]),
      .slew_speed_o(slw_w[k]), .pin_mode_o(mode_w[k]));
  end
  task automatic apb(input logic w, input logic [GP_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (rdy_w[0] !== 1'b1);
    rd = rd_w;
    er = er_w;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    #1;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    logic [31:0] rst_exp [3][4];
    rst_exp = '{'{GP_RST_MODE_A, GP_RST_ZERO, GP_RST_ZERO, GP_RST_PULL_A},
      '{GP_RST_MODE_B, GP_RST_ZERO, GP_RST_SLEW_B, GP_RST_PULL_B},
      '{GP_RST_ZERO, GP_RST_ZERO, GP_RST_ZERO, GP_RST_ZERO}};
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b0, 12'(4 * r), 32'h0000_0000);
      for (int k = 0; k < 3; k++)
        check("reset image", rst_exp[k][r], rd[k]);
    end
    check("mode pins A", GP_RST_MODE_A, mode_w[0]);
    check("slew pins B", GP_RST_SLEW_B, slw_w[1]);
    check("pull up A", 32'h0000_A000, 32'(pu_w[0]));
    check("pull down A", 32'h0000_4000, 32'(pd_w[0]));
    check("pull up B", 32'h0000_0010, 32'(pu_w[1]));
    check("pull down B", 32'h0000_0000, 32'(pd_w[1]));
    apb(1'b0, GP_OFF_BIT_CLEAR, 32'h0000_0000);
    check("clear read", 32'h0000_0000, rd[0]);
    check("absent clear", 32'h0000_0001, 32'(er[2]));
    apb(1'b1, GP_OFF_LATCH, 32'hFFFF_FFFF);
    apb(1'b0, GP_OFF_LATCH, 32'h0000_0000);
    check("latch read", 32'h0000_FFFF, rd[0]);
    apb(1'b1, GP_OFF_BIT_CLEAR, 32'hFFFF_0005);
    check("latch cleared", 32'h0000_FFFA, 32'(pout_w[0]));
    check("latch kept", 32'h0000_FFFF, 32'(pout_w[2]));
    lat = 16'hFFFA;
    for (int i = 15; i >= 0; i--)
    begin
      apb(1'b1, GP_OFF_BIT_CLEAR, 32'h0000_0001 << i);
      lat[i] = 1'b0;
      check("walking clear", 32'(lat), 32'(pout_w[0]));
    end
    apb(1'b1, GP_OFF_PIN_MODE, 32'h0000_0005);
    apb(1'b1, GP_OFF_LATCH, 32'h0000_0003);
    apb(1'b1, GP_OFF_BIT_CLEAR, 32'h0000_0001);
    check("pin out", 32'h0000_0002, 32'(pout_w[0]));
    check("pin enable", 32'h0000_FFFC, 32'(oen_w[0]));
    apb(1'b0, 12'h018, 32'h0000_0000);
    check("unmapped", 32'h0000_0001, 32'(er[0]));
    apb(1'b0, GP_OFF_PIN_IN, 32'h0000_0000);
    check("pin input", 32'h0000_A5C3, rd[0]);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, GP_OFF_PIN_MODE, 32'h0000_0000);
    check("mode after reset", GP_RST_MODE_A, rd[0]);
    check("latch after reset", 32'h0000_0000, 32'(pout_w[0]));
    print_verdict();
  end
  initial
  begin
    #(50 * 4000);
    errors++;
    print_verdict();
  end
endmodule // gp_port_bench
